// *** rtl/lfs_pkg.sv ***
package lfs_pkg;
  localparam logic [7:0] LFS_ADDR_CTRL2 = 8'h11;
  localparam logic [7:0] LFS_ADDR_RING_MODE = 8'h12;
  localparam logic [7:0] LFS_ADDR_STATUS = 8'h13;
  localparam logic [7:0] LFS_ADDR_IRQ_STAT = 8'h30;
  localparam logic [7:0] LFS_ADDR_IRQ_MASK = 8'h31;
  localparam int LFS_BIT_TONE_SEEN = 0;
  localparam int LFS_BIT_RX_OVERLOAD_STICKY = 1;
  localparam int LFS_BIT_TONE_EN = 2;
  localparam int LFS_BIT_RECT_SEL = 1;
  localparam int LFS_BIT_OVERCURRENT = 0;
  localparam int LFS_BIT_DROPOUT = 1;
  localparam int LFS_BIT_RX_OVERLOAD_LIVE = 2;
  localparam logic [7:0] LFS_CTRL2_RW_MASK = 8'hFC;
  localparam logic [7:0] LFS_RING_MODE_RW_MASK = 8'h06;
  localparam logic [7:0] LFS_RESET_BYTE = 8'h00;
  localparam int LFS_IRQ_BITS = 4;
  localparam int LFS_IRQ_RX_OVERLOAD = 0;
  localparam int LFS_IRQ_TONE = 1;
  localparam int LFS_IRQ_OVERCURRENT = 2;
  localparam int LFS_IRQ_DROPOUT = 3;
  localparam logic [3:0] LFS_IRQ_RESET = 4'h0;
  localparam int LFS_CLK_HZ = 100_000_000;
  localparam int LFS_ONESHOT_SEC = 5;
  localparam longint LFS_ONESHOT_CYC = longint'(LFS_CLK_HZ) * LFS_ONESHOT_SEC;
  localparam int LFS_LIMIT_160_MA = 160;
  localparam int LFS_LIMIT_60_MA = 60;
  localparam logic [7:0] LFS_LIMIT_160_CODE = 8'hA0;
  localparam logic [7:0] LFS_LIMIT_60_CODE = 8'h3C;

  typedef struct packed {
    logic rx_overload;
    logic supply_disrupt;
    logic loop_current;
    logic [7:0] loop_current_ma;
    logic on_hook;
    logic line_side_en;
    logic settle_mask;
    logic ring_half;
    logic ring_full;
    logic ring_valid_env;
    logic ring_cross;
  } lfs_line_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } lfs_bus_type;

  typedef enum logic [1:0] {
    LFS_RING_HALF,
    LFS_RING_FULL,
    LFS_RING_ENV,
    LFS_RING_ONESHOT
  } lfs_ring_mode_type;
endpackage

// *** rtl/lfs_sticky_bit.sv ***
`timescale 1ns/1ps
`default_nettype none
module lfs_sticky_bit (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic set,
  input wire logic clr,
  output logic q
);
  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// *** rtl/lfs_ring_oneshot.sv ***
`timescale 1ns/1ps
`default_nettype none
module lfs_ring_oneshot #(
  parameter longint CYCLES = 500_000_000
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic trigger,
  output logic pulse
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);
  logic [W-1:0] count;
  if (CYCLES < 1) begin : g_bad_len
    $error("one-shot length must be at least one cycle");
  end
  // fixed length from the first crossing; later crossings do not retrigger
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pulse <= 1'b0;
      count <= '0;
    end else if (!pulse && trigger) begin
      pulse <= 1'b1;
      count <= '0;
    end else if (pulse) begin
      if (count == LAST) begin
        pulse <= 1'b0;
      end
      count <= count + W'(1);
    end
  end
endmodule
`default_nettype wire

// *** rtl/lfs_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module lfs_regs
  import lfs_pkg::*;
#(
  parameter longint ONESHOT_CYCLES = LFS_ONESHOT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire lfs_bus_type bus,
  output logic [7:0] rdata,
  input wire lfs_line_type line,
  input wire logic ring_validation_en,
  input wire logic current_limit_select,
  output logic rx_overload_irq_flag,
  input wire logic rx_overload_irq_clr,
  output logic ring_detect_out,
  output logic hold_off_hook,
  output logic irq
);
  logic [7:0] ctrl2_rw;
  logic [7:0] ring_mode;
  logic rx_overload_sticky;
  logic billing_tone_seen;
  logic billing_tone_detect_en;
  logic ring_rectifier_select;
  logic rx_overload_live;
  logic supply_dropout_flag;
  logic loop_overcurrent_flag;
  logic [7:0] limit_code;
  logic [LFS_IRQ_BITS-1:0] irq_stat;
  logic [LFS_IRQ_BITS-1:0] irq_mask;
  logic [LFS_IRQ_BITS-1:0] irq_event;
  logic ring_oneshot;
  logic wr_ctrl2;
  logic sticky_clr;
  logic tone_clr;
  logic [7:0] ctrl2_rd;
  logic [7:0] status_rd;
  logic [7:0] next_rdata;
  logic live_q;
  logic overcurrent_q;
  logic dropout_q;
  lfs_ring_mode_type mode;

  if (ONESHOT_CYCLES < 1) begin : g_bad_oneshot
    $error("one-shot length must be positive");
  end

  assign wr_ctrl2 = bus.wr && (bus.addr == LFS_ADDR_CTRL2);
  assign billing_tone_detect_en = ctrl2_rw[LFS_BIT_TONE_EN];
  assign ring_rectifier_select = ring_mode[LFS_BIT_RECT_SEL];
  assign sticky_clr = wr_ctrl2 && !bus.wdata[LFS_BIT_RX_OVERLOAD_STICKY];
  assign tone_clr = wr_ctrl2 && !bus.wdata[LFS_BIT_TONE_EN];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ctrl2_rw <= LFS_RESET_BYTE;
    end else if (wr_ctrl2) begin
      ctrl2_rw <= bus.wdata & LFS_CTRL2_RW_MASK;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ring_mode <= LFS_RESET_BYTE;
    end else if (bus.wr && bus.addr == LFS_ADDR_RING_MODE) begin
      ring_mode <= bus.wdata & LFS_RING_MODE_RW_MASK;
    end
  end

  lfs_sticky_bit u_rx_sticky (
    .clk_sys(clk_sys),
    .rst(rst),
    .set(line.rx_overload),
    .clr(sticky_clr),
    .q(rx_overload_sticky)
  );

  // detection only while enabled; disabled means the flag is not functional
  lfs_sticky_bit u_tone_seen (
    .clk_sys(clk_sys),
    .rst(rst),
    .set(line.supply_disrupt && billing_tone_detect_en),
    .clr(tone_clr),
    .q(billing_tone_seen)
  );

  // interrupt flag of the outside register: also cleared by its own clear strobe
  lfs_sticky_bit u_rx_irq_flag (
    .clk_sys(clk_sys),
    .rst(rst),
    .set(line.rx_overload),
    .clr(sticky_clr || rx_overload_irq_clr),
    .q(rx_overload_irq_flag)
  );

  assign hold_off_hook = billing_tone_detect_en && line.supply_disrupt && !line.on_hook;

  always_comb begin
    if (current_limit_select) begin
      limit_code = LFS_LIMIT_60_CODE;
    end else begin
      limit_code = LFS_LIMIT_160_CODE;
    end
  end

  // live status registered to keep read data from flops
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      live_q <= 1'b0;
      dropout_q <= 1'b0;
      overcurrent_q <= 1'b0;
    end else begin
      live_q <= line.rx_overload && !line.settle_mask;
      dropout_q <= !line.loop_current || (line.on_hook && line.line_side_en);
      overcurrent_q <= line.loop_current_ma > limit_code;
    end
  end
  assign rx_overload_live = live_q;
  assign supply_dropout_flag = dropout_q;
  assign loop_overcurrent_flag = overcurrent_q;

  lfs_ring_oneshot #(.CYCLES(ONESHOT_CYCLES)) u_oneshot (
    .clk_sys(clk_sys),
    .rst(rst),
    .trigger(line.ring_cross),
    .pulse(ring_oneshot)
  );

  assign mode = lfs_ring_mode_type'({ring_validation_en, ring_rectifier_select});

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ring_detect_out <= 1'b0;
    end else begin
      unique case (mode)
        LFS_RING_HALF: ring_detect_out <= line.ring_half;
        LFS_RING_FULL: ring_detect_out <= line.ring_full;
        LFS_RING_ENV: ring_detect_out <= line.ring_valid_env;
        LFS_RING_ONESHOT: ring_detect_out <= ring_oneshot;
      endcase
    end
  end

  always_comb begin
    irq_event = '0;
    irq_event[LFS_IRQ_RX_OVERLOAD] = line.rx_overload;
    irq_event[LFS_IRQ_TONE] = line.supply_disrupt && billing_tone_detect_en;
    irq_event[LFS_IRQ_OVERCURRENT] = overcurrent_q;
    irq_event[LFS_IRQ_DROPOUT] = dropout_q;
  end

  // write one to clear; a fresh event in the same cycle keeps its bit
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_stat <= LFS_IRQ_RESET;
    end else if (bus.wr && bus.addr == LFS_ADDR_IRQ_STAT) begin
      irq_stat <= (irq_stat & ~bus.wdata[LFS_IRQ_BITS-1:0]) | irq_event;
    end else begin
      irq_stat <= irq_stat | irq_event;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_mask <= LFS_IRQ_RESET;
    end else if (bus.wr && bus.addr == LFS_ADDR_IRQ_MASK) begin
      irq_mask <= bus.wdata[LFS_IRQ_BITS-1:0];
    end
  end

  assign irq = |(irq_stat & irq_mask);

  always_comb begin
    ctrl2_rd = ctrl2_rw;
    ctrl2_rd[LFS_BIT_RX_OVERLOAD_STICKY] = rx_overload_sticky;
    ctrl2_rd[LFS_BIT_TONE_SEEN] = billing_tone_seen;
    status_rd = LFS_RESET_BYTE;
    status_rd[LFS_BIT_RX_OVERLOAD_LIVE] = rx_overload_live;
    status_rd[LFS_BIT_DROPOUT] = supply_dropout_flag;
    status_rd[LFS_BIT_OVERCURRENT] = loop_overcurrent_flag;
  end

  // status register has no write path, so writes there fall through
  always_comb begin
    unique case (bus.addr)
      LFS_ADDR_CTRL2: next_rdata = ctrl2_rd;
      LFS_ADDR_RING_MODE: next_rdata = ring_mode;
      LFS_ADDR_STATUS: next_rdata = status_rd;
      LFS_ADDR_IRQ_STAT: next_rdata = {{(8-LFS_IRQ_BITS){1'b0}}, irq_stat};
      LFS_ADDR_IRQ_MASK: next_rdata = {{(8-LFS_IRQ_BITS){1'b0}}, irq_mask};
      default: next_rdata = LFS_RESET_BYTE;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata <= LFS_RESET_BYTE;
    end else if (bus.rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= LFS_RESET_BYTE;
    end
  end
endmodule
`default_nettype wire

// *** test/lfs_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module lfs_checker
  import lfs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire lfs_bus_type bus,
  input wire logic [7:0] rdata,
  input wire lfs_line_type line,
  input wire logic ring_validation_en,
  input wire logic current_limit_select,
  input wire logic rx_overload_irq_flag,
  input wire logic rx_overload_irq_clr,
  input wire logic ring_detect_out,
  input wire logic hold_off_hook,
  input wire logic irq
);
  logic rect_sel;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // mirror of the rectifier select, since the mode is not visible at the ports
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rect_sel <= 1'b0;
    end else if (bus.wr && bus.addr == LFS_ADDR_RING_MODE) begin
      rect_sel <= bus.wdata[LFS_BIT_RECT_SEL];
    end
  end
  // the past-reset guard keeps sources seen during reset out of the check
  sequence s_mode(v, f);
    !$past(rst) && $past(ring_validation_en) == v && $past(rect_sel) == f;
  endsequence
  sequence s_sticky_clr;
    bus.wr && bus.addr == LFS_ADDR_CTRL2 && !bus.wdata[LFS_BIT_RX_OVERLOAD_STICKY]
      && !line.rx_overload;
  endsequence
  sequence s_status_read;
    bus.rd && bus.addr == LFS_ADDR_STATUS;
  endsequence
  a_ring_half:
    assert property (s_mode(0, 0) |-> ring_detect_out == $past(line.ring_half))
    else $error("ring output not half-wave");
  a_ring_full:
    assert property (s_mode(0, 1) |-> ring_detect_out == $past(line.ring_full))
    else $error("ring output not full-wave");
  a_ring_env:
    assert property (s_mode(1, 0) |-> ring_detect_out == $past(line.ring_valid_env))
    else $error("ring output not envelope");
  a_flag_set:
    assert property (line.rx_overload |=> rx_overload_irq_flag)
    else $error("overload flag not set");
  a_flag_wclr:
    assert property (s_sticky_clr |=> !rx_overload_irq_flag)
    else $error("overload flag not cleared by write");
  a_flag_hold:
    assert property (rx_overload_irq_flag && !rx_overload_irq_clr && !bus.wr
      |=> rx_overload_irq_flag)
    else $error("overload flag dropped");
  a_status_rsvd:
    assert property ($past(bus.rd) && $past(bus.addr) == LFS_ADDR_STATUS && !$past(rst)
      |-> rdata[7:3] == 5'h00)
    else $error("status reserved bits not zero");
  a_hold_off:
    assert property (line.on_hook || !line.supply_disrupt |-> !hold_off_hook)
    else $error("off-hook hold without disruption");
  // live bits reach the read port two edges after the line inputs
  a_status_bits:
    assert property (s_status_read |=> rdata[2:0] == {
      $past(line.rx_overload && !line.settle_mask, 2),
      $past(!line.loop_current || (line.on_hook && line.line_side_en), 2),
      $past(line.loop_current_ma > (current_limit_select ? LFS_LIMIT_60_MA
        : LFS_LIMIT_160_MA), 2)})
    else $error("status bits do not follow the line");
endmodule
bind lfs_regs lfs_checker u_chk (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
  .line(line), .ring_validation_en(ring_validation_en),
  .current_limit_select(current_limit_select), .rx_overload_irq_flag(rx_overload_irq_flag),
  .rx_overload_irq_clr(rx_overload_irq_clr), .ring_detect_out(ring_detect_out),
  .hold_off_hook(hold_off_hook), .irq(irq));
`default_nettype wire

// *** test/lfs_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module lfs_host
  import lfs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [7:0] rdata,
  output var lfs_bus_type bus
);
  initial bus = '0;
  // each access drops its strobe at the edge that ends it, so calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lfs_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic rve = 1'b0;
  logic cls = 1'b0;
  logic clr = 1'b0;
  logic flag, rdo, hold, irq;
  logic [7:0] rdata, v;
  lfs_line_type line = lfs_line_type'(18'h08000);
  lfs_bus_type bus;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  // short one-shot so the timeout path is reachable in a few cycles
  localparam int ONESHOT = 20;
  always #5 clk_sys = ~clk_sys;
  lfs_host host (.clk_sys(clk_sys), .rdata(rdata), .bus(bus));
  lfs_regs #(.ONESHOT_CYCLES(ONESHOT)) dut (.clk_sys(clk_sys), .rst(rst), .bus(bus),
    .rdata(rdata), .line(line), .ring_validation_en(rve), .current_limit_select(cls),
    .rx_overload_irq_flag(flag), .rx_overload_irq_clr(clr), .ring_detect_out(rdo),
    .hold_off_hook(hold), .irq(irq));
  task automatic test_done();
    if (err_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic nx();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, v);
    chk("rdata", e, v);
  endtask
  // status lags the line by a cycle; the read starts one edge after the change
  task automatic st(input logic [17:0] l, input logic s, input logic [7:0] e);
    @(posedge clk_sys);
    line <= lfs_line_type'(l);
    cls <= s;
    rc(LFS_ADDR_STATUS, e);
  endtask
  task automatic rg(input logic [1:0] m, input logic [3:0] s, input logic e);
    @(posedge clk_sys);
    rve <= m[1];
    host.wr(LFS_ADDR_RING_MODE, {6'h00, m[0], 1'b0});
    @(posedge clk_sys);
    line[3:0] <= s;
    nx();
    chk("ring_detect_out", {7'h00, e}, {7'h00, rdo});
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    rc(8'h11, 8'h00);
    rc(8'h12, 8'h00);
    rc(8'h13, 8'h00);
    host.wr(8'h12, 8'hFF);
    rc(8'h12, 8'h06);
    rc(8'h40, 8'h00);
    st({3'b001, 8'hA1, 7'h00}, 1'b0, 8'h01);
    st({3'b001, 8'hA0, 7'h00}, 1'b0, 8'h00);
    st({3'b001, 8'h3D, 7'h00}, 1'b1, 8'h01);
    st({3'b001, 8'h3C, 7'h00}, 1'b1, 8'h00);
    st({3'b000, 8'h00, 7'h00}, 1'b0, 8'h02);
    st({3'b001, 8'h00, 7'h60}, 1'b0, 8'h02);
    st({3'b101, 8'h00, 7'h00}, 1'b0, 8'h04);
    host.wr(8'h13, 8'hFF);
    rc(8'h13, 8'h04);
    st({3'b101, 8'h00, 7'h10}, 1'b0, 8'h00);
    st({3'b001, 8'h00, 7'h00}, 1'b0, 8'h00);
    host.wr(8'h11, 8'h00);
    host.wr(8'h30, 8'hFF);
    host.wr(8'h31, 8'h01);
    nx();
    chk("flag", 8'h00, {7'h00, flag});
    chk("irq", 8'h00, {7'h00, irq});
    @(posedge clk_sys);
    line.rx_overload <= 1'b1;
    @(posedge clk_sys);
    line.rx_overload <= 1'b0;
    nx();
    chk("flag", 8'h01, {7'h00, flag});
    chk("irq", 8'h01, {7'h00, irq});
    rc(8'h11, 8'h02);
    host.wr(8'h31, 8'h00);
    nx();
    chk("irq", 8'h00, {7'h00, irq});
    host.wr(8'h31, 8'h01);
    nx();
    chk("irq", 8'h01, {7'h00, irq});
    host.wr(8'h30, 8'h01);
    nx();
    chk("irq", 8'h00, {7'h00, irq});
    host.wr(8'h11, 8'h00);
    rc(8'h11, 8'h00);
    chk("flag", 8'h00, {7'h00, flag});
    @(posedge clk_sys);
    line.rx_overload <= 1'b1;
    @(posedge clk_sys);
    line.rx_overload <= 1'b0;
    nx();
    chk("flag", 8'h01, {7'h00, flag});
    @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    nx();
    chk("flag", 8'h00, {7'h00, flag});
    host.wr(8'h11, 8'h04);
    @(posedge clk_sys);
    line.supply_disrupt <= 1'b1;
    nx();
    chk("hold_off_hook", 8'h01, {7'h00, hold});
    @(posedge clk_sys);
    line.supply_disrupt <= 1'b0;
    rc(8'h11, 8'h05);
    rc(8'h30, 8'h03);
    rc(8'h31, 8'h01);
    host.wr(8'h11, 8'h00);
    rc(8'h11, 8'h00);
    rg(2'd0, 4'h8, 1'b1);
    rg(2'd0, 4'h6, 1'b0);
    rg(2'd1, 4'h4, 1'b1);
    rg(2'd1, 4'hA, 1'b0);
    rg(2'd2, 4'h2, 1'b1);
    rg(2'd2, 4'hC, 1'b0);
    rg(2'd3, 4'h0, 1'b0);
    @(posedge clk_sys);
    line.ring_cross <= 1'b1;
    @(posedge clk_sys);
    line.ring_cross <= 1'b0;
    nx();
    chk("ring_detect_out", 8'h01, {7'h00, rdo});
    repeat (ONESHOT - 2) @(posedge clk_sys);
    nx();
    chk("ring_detect_out", 8'h01, {7'h00, rdo});
    nx();
    chk("ring_detect_out", 8'h00, {7'h00, rdo});
    test_done();
  end
endmodule
`default_nettype wire
